// File: test_ucr_serial_port.sv
// Self-checking bench: registers, shift mode, loopback frames, rates
`timescale 1ns/1ns
`default_nettype none
`include "ucr_defines.svh"
module test_ucr_serial_port;
  logic        i_mclk, i_reset, i_wr, i_rd, i_t1_ovf, i_t2_ovf, i_rxd;
  logic [7:0]  i_addr, i_wdata, o_rdata, got, send, last, b;
  logic        o_txd, o_rxd_out, o_rxd_oe, m_data, pin, loop, m_en, m_load;
  logic        rd_d;
  logic [1:0]  src;
  logic [31:0] rnd;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int          n_fail, checks_done, cyc, novf, t0, n0, d;
  assign pin   = o_rxd_oe ? o_rxd_out : m_data;
  assign i_rxd = loop ? o_txd : pin;
  ucr_serial_port ucr_serial_port_i (.i_mclk, .i_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_t1_ovf, .i_t2_ovf, .o_txd, .i_rxd,
    .o_rxd_out, .o_rxd_oe);
  ucr_shift_slave ucr_shift_slave_i (.i_mclk, .i_en(m_en), .i_load(m_load),
    .i_byte(send), .i_sclk(o_txd), .i_pin(pin), .o_data(m_data),
    .o_got(got));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] s);
    checks_done++;
    if (x !== s) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // A free gap cycle after each strobe keeps every drive to one per step
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    i_addr  <= a;
    i_wdata <= x;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic [7:0] m);
    exp_q.push_back({m, x});
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    @(posedge i_mclk);
  endtask : rd
  task automatic wait_flag(input int f, input int lim);
    int n;
    n = 0;
    do begin
      rd(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h00, 8'h00);
      @(posedge i_mclk);
      n++;
    end while (last[f] !== 1'b1 && n < lim);
    chk("flag", 16'h1, {15'h0, last[f]});
  endtask : wait_flag
  // Timer pulses, bench counters and the random source share one seed
  initial begin
    {i_t1_ovf, i_t2_ovf, rd_d} = 3'h0;
    rnd = 32'h0;
    {novf, cyc} = 0;
    void'($urandom(32'hc0d8));
    forever begin
      @(posedge i_mclk);
      if (src == 2'h1 ? i_t1_ovf : src == 2'h2 && i_t2_ovf) novf++;
      cyc++;
      rd_d     <= i_rd;
      rnd      <= $urandom;
      i_t1_ovf <= ($urandom % 3) == 0;
      i_t2_ovf <= ($urandom % 3) == 0;
    end
  end
  always @(posedge i_mclk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      last = o_rdata;
      chk("rdata", {8'h00, e[7:0]}, {8'h00, o_rdata & e[15:8]});
    end
  end
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {i_reset, m_load} = 2'h3;
    {i_wr, i_rd, loop, m_en, src} = 6'h00;
    {i_addr, i_wdata, send} = 24'h00005a;
    {n_fail, checks_done} = 0;
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    m_load  <= 1'b0;
    rd(`UCR_ADDR_SERIAL_CONTROL_REGISTER, `UCR_SERIAL_CONTROL_REGISTER_RESET, 8'hff);
    rd(`UCR_ADDR_POWER_AND_BAUD_CONTROL, `UCR_POWER_AND_BAUD_CONTROL_RESET, 8'hff);
    rd(`UCR_ADDR_RSEL, 8'h00, 8'h07);
    rd(8'h10, 8'h00, 8'hff);
    wr(`UCR_ADDR_POWER_AND_BAUD_CONTROL, 8'hff);
    rd(`UCR_ADDR_POWER_AND_BAUD_CONTROL, `UCR_POWER_AND_BAUD_CONTROL_MASK, 8'hff);
    m_en <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(`UCR_ADDR_RSEL, 8'(s * 4));
      b  = rnd[7:0];
      t0 = cyc;
      wr(`UCR_ADDR_SERIAL_DATA_BUFFER, b);
      wait_flag(`UCR_SERIAL_CONTROL_REGISTER_TI, 60);
      d = 96 >> s;
      chk("m0_time", 16'h1, {15'h0, (cyc - t0) inside {[d:d + 14]}});
      chk("shift_out", {8'h00, b}, {8'h00, got});
      wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h00);
    end
    b = rnd[7:0];
    send   <= b;
    m_load <= 1'b1;
    @(posedge i_mclk);
    m_load <= 1'b0;
    wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h10);
    wait_flag(`UCR_SERIAL_CONTROL_REGISTER_RI, 60);
    rd(`UCR_ADDR_SERIAL_DATA_BUFFER, b, 8'hff);
    {m_en, loop} <= 2'h1;
    wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h50);
    for (int c = 0; c < 3; c++) begin
      wr(`UCR_ADDR_POWER_AND_BAUD_CONTROL, c == 1 ? 8'h80 : 8'h00);
      wr(`UCR_ADDR_RSEL, c == 2 ? 8'h03 : 8'h00);
      src <= c == 2 ? 2'h2 : 2'h1;
      d  = c == 0 ? 2 : 1;
      b  = rnd[7:0];
      n0 = novf;
      wr(`UCR_ADDR_SERIAL_DATA_BUFFER, b);
      wait_flag(`UCR_SERIAL_CONTROL_REGISTER_TI, 400);
      chk("ovf_count", 16'h1,
          {15'h0, (novf - n0) inside {[143 * d - 1:144 * d + 6]}});
      wait_flag(`UCR_SERIAL_CONTROL_REGISTER_RI, 200);
      rd(`UCR_ADDR_SERIAL_DATA_BUFFER, b, 8'hff);
      rd(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h57, 8'hff);
      wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h50);
    end
    wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h51);
    wait_flag(`UCR_SERIAL_CONTROL_REGISTER_RI, 1);
    wr(`UCR_ADDR_SERIAL_DATA_BUFFER, ~b);
    wait_flag(`UCR_SERIAL_CONTROL_REGISTER_TI, 400);
    repeat (200) @(posedge i_mclk);
    rd(`UCR_ADDR_SERIAL_DATA_BUFFER, b, 8'hff);
    rd(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h53, 8'hff);
    // Mode 3 loopback: ninth bit set, multiprocessor check on
    wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'hf8);
    wr(`UCR_ADDR_SERIAL_DATA_BUFFER, ~b);
    wait_flag(`UCR_SERIAL_CONTROL_REGISTER_TI, 400);
    rd(`UCR_ADDR_SERIAL_DATA_BUFFER, ~b, 8'hff);
    rd(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'hff, 8'hff);
    loop <= 1'b0;
    wr(`UCR_ADDR_RSEL, 8'h00);
    wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h80);
    for (int k = 0; k < 2; k++) begin
      wr(`UCR_ADDR_POWER_AND_BAUD_CONTROL, k == 1 ? 8'h80 : 8'h00);
      t0 = cyc;
      wr(`UCR_ADDR_SERIAL_DATA_BUFFER, rnd[7:0]);
      wait_flag(`UCR_SERIAL_CONTROL_REGISTER_TI, 300);
      d = 640 >> k;
      chk("m2_time", 16'h1, {15'h0, (cyc - t0) inside {[d - 8:d + 16]}});
      wr(`UCR_ADDR_SERIAL_CONTROL_REGISTER, 8'h80);
    end
    end_of_test();
  end
endmodule : test_ucr_serial_port
`default_nettype wire

// File: ucr_defines.svh
// Register offsets, field positions, reset values and counts of the serial port
// Summary of operation
// - Mode bits select mode 0 sync 8-bit, mode 1 10-bit, modes 2/3 11-bit.
// - Mode 0 bit rate is clock/12, or clock/6 in six-clock mode.
// - Mode 2 bit rate is clock/64 or /32, halved divisors in six-clock mode.
// - Modes 1/3 use Timer 1 overflow /32 or /16, or Timer 2 overflow /16.
// - Double-rate bit doubles mode 2 rate, and modes 1/3 only on Timer 1.
// - Buffer address writes the transmit register and reads the receive register.
// - Any buffer write starts a transmission in the current mode.
// - Mode 0 drives shift clock on transmit pin, data both ways on receive pin.
// - Mode 0 moves data LSB first, one bit per shift clock.
// - Mode 0 transmit shifts eight bits then sets transmit-complete.
// - Mode 0 receive runs while enabled and receive-complete clear; eight bits.
// - Mode 1 frame is start 0, eight data bits LSB first, stop 1.
// - Timer 2 select bits choose Timer 1 or Timer 2 as rate source.
// - Mode 1 transmit sends start, data, stop; flag set when stop appears.
// - Mode 1 receiver starts on a falling edge while enabled.
// - Mode 1 load decision is taken in the middle of the stop bit.
// - Load only if receive flag clear and check off or stop bit high.
`ifndef UCR_DEFINES_SVH
`define UCR_DEFINES_SVH

`define UCR_ADDR_POWER_AND_BAUD_CONTROL      8'h87
`define UCR_ADDR_SERIAL_CONTROL_REGISTER      8'h98
`define UCR_ADDR_SERIAL_DATA_BUFFER      8'h99
`define UCR_ADDR_RSEL      8'h9a

`define UCR_SERIAL_CONTROL_REGISTER_RESET     8'h00
`define UCR_POWER_AND_BAUD_CONTROL_RESET     8'h00
`define UCR_RSEL_RESET     3'h0
`define UCR_POWER_AND_BAUD_CONTROL_MASK      8'h9f

`define UCR_SERIAL_CONTROL_REGISTER_MP        5
`define UCR_SERIAL_CONTROL_REGISTER_REN       4
`define UCR_SERIAL_CONTROL_REGISTER_TB8       3
`define UCR_SERIAL_CONTROL_REGISTER_RB8       2
`define UCR_SERIAL_CONTROL_REGISTER_TI        1
`define UCR_SERIAL_CONTROL_REGISTER_RI        0
`define UCR_POWER_AND_BAUD_CONTROL_DBL       7
`define UCR_RSEL_TX_T2     0
`define UCR_RSEL_RX_T2     1
`define UCR_RSEL_SIX       2

`define UCR_M0_HALF_12T    4'h6
`define UCR_M0_HALF_6T     4'h3
`define UCR_M2_DIV_12T     4'h4
`define UCR_M2_DIV_12T_DBL 4'h2
`define UCR_M2_DIV_6T      4'h2
`define UCR_M2_DIV_6T_DBL  4'h1
`define UCR_T1_DIV         4'h2
`define UCR_T1_DIV_DBL     4'h1
`define UCR_OVS_LAST       4'hf
`define UCR_OVS_MID        4'h7
`define UCR_BITS_M1        4'ha
`define UCR_BITS_M23       4'hb
`define UCR_RX_DECIDE      4'h9

`endif

// File: ucr_pkg.sv
// Types shared by the serial port modules
package ucr_pkg;

  typedef enum logic [1:0] {
    UCR_MODE0 = 2'b00,
    UCR_MODE1 = 2'b01,
    UCR_MODE2 = 2'b10,
    UCR_MODE3 = 2'b11
  } ucr_mode_t;

  typedef enum logic [1:0] {
    UCR_SY_IDLE = 2'b00,
    UCR_SY_TX   = 2'b01,
    UCR_SY_RX   = 2'b10
  } ucr_sy_t;

  typedef enum logic [0:0] {
    UCR_AS_IDLE = 1'b0,
    UCR_AS_RUN  = 1'b1
  } ucr_as_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } ucr_div_t;

  typedef struct packed {
    logic [7:0]  serial_control_register;
    logic [7:0]  power_and_baud_control;
    logic [2:0]  rsel;
    logic [7:0]  rxbuf;
    logic [7:0]  rdata;
    ucr_sy_t     sy_state;
    logic        sy_phase;
    logic [2:0]  sy_bit;
    logic [7:0]  sy_sh;
    ucr_as_t     tx_state;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
    ucr_as_t     rx_state;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_last;
    logic        txd;
    logic        rxd_out;
    logic        rxd_oe;
  } ucr_state_t;

endpackage : ucr_pkg

// File: ucr_serial_port.sv
// Serial port with synchronous shift mode and asynchronous frame modes
`timescale 1ns/1ns
`default_nettype none
`include "ucr_defines.svh"
module ucr_serial_port (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Timer overflow pulses
  input  wire logic       i_t1_ovf,
  input  wire logic       i_t2_ovf,
  // Serial pins
  output logic            o_txd,
  input  wire logic       i_rxd,
  output logic            o_rxd_out,
  output logic            o_rxd_oe
);
  import ucr_pkg::*;

  ucr_state_t q;
  ucr_state_t d;

  ucr_mode_t  mode;
  logic       six_mode;
  logic       dbl;
  logic       buf_wr;
  logic       sy_start;
  logic       ti_set;
  logic       ri_set;
  logic       rx_load;
  logic [7:0] rx_byte;
  logic       rb8_val;
  logic [3:0] osc_div;
  logic [3:0] t1_div;
  logic       osc_tick;
  logic       t1_tick;
  logic       tx_tick;
  logic       rx_tick;
  logic [3:0] tx_bits;

  assign mode     = ucr_mode_t'(q.serial_control_register[7:6]);
  assign six_mode = q.rsel[`UCR_RSEL_SIX];
  assign dbl      = q.power_and_baud_control[`UCR_POWER_AND_BAUD_CONTROL_DBL];
  assign buf_wr   = i_wr && (i_addr == `UCR_ADDR_SERIAL_DATA_BUFFER);

  // Oscillator divider: half shift-clock period in mode 0,
  // sixteenth of a bit in mode 2
  always_comb begin
    if (mode == UCR_MODE0) begin
      osc_div = six_mode ? `UCR_M0_HALF_6T : `UCR_M0_HALF_12T;
    end else if (six_mode) begin
      osc_div = dbl ? `UCR_M2_DIV_6T_DBL : `UCR_M2_DIV_6T;
    end else begin
      osc_div = dbl ? `UCR_M2_DIV_12T_DBL : `UCR_M2_DIV_12T;
    end
  end

  // Timer 1 overflow halved unless the double-rate bit is set
  assign t1_div = dbl ? `UCR_T1_DIV_DBL : `UCR_T1_DIV;

  ucr_tick_div u_osc_div (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_en    (1'b1),
    .i_clr   (sy_start),
    .i_div   (osc_div),
    .o_tick  (osc_tick)
  );

  ucr_tick_div u_t1_div (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_en    (i_t1_ovf),
    .i_clr   (1'b0),
    .i_div   (t1_div),
    .o_tick  (t1_tick)
  );

  // Sixteen-times ticks; Timer 2 is never affected by the double-rate bit
  always_comb begin
    if (mode == UCR_MODE2) begin
      tx_tick = osc_tick;
      rx_tick = osc_tick;
    end else begin
      tx_tick = q.rsel[`UCR_RSEL_TX_T2] ? i_t2_ovf : t1_tick;
      rx_tick = q.rsel[`UCR_RSEL_RX_T2] ? i_t2_ovf : t1_tick;
    end
  end

  assign tx_bits  = (mode == UCR_MODE1) ? `UCR_BITS_M1 : `UCR_BITS_M23;
  assign sy_start = (mode == UCR_MODE0) && (buf_wr ||
                    ((q.sy_state == UCR_SY_IDLE) &&
                     q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_REN] && !q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RI]));

  always_comb begin
    d       = q;
    ti_set  = 1'b0;
    ri_set  = 1'b0;
    rx_load = 1'b0;
    rx_byte = 8'h00;
    rb8_val = 1'b0;

    // Register reads: data stands the cycle after the strobe
    d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `UCR_ADDR_SERIAL_CONTROL_REGISTER: d.rdata = q.serial_control_register;
        `UCR_ADDR_POWER_AND_BAUD_CONTROL: d.rdata = q.power_and_baud_control;
        `UCR_ADDR_SERIAL_DATA_BUFFER: d.rdata = q.rxbuf;
        `UCR_ADDR_RSEL: d.rdata = {5'h00, q.rsel};
        default:        d.rdata = 8'h00;
      endcase
    end

    // Register writes; flags written here may be overridden by a set below
    if (i_wr) begin
      case (i_addr)
        `UCR_ADDR_SERIAL_CONTROL_REGISTER: d.serial_control_register = i_wdata;
        `UCR_ADDR_POWER_AND_BAUD_CONTROL: d.power_and_baud_control = i_wdata & `UCR_POWER_AND_BAUD_CONTROL_MASK;
        `UCR_ADDR_RSEL: d.rsel = i_wdata[2:0];
        default:        d.rsel = q.rsel;
      endcase
    end

    // Mode 0: device always owns the shift clock, partner only follows
    if (mode != UCR_MODE0) begin
      // Leaving shift mode mid-byte must not leave the data pin driven
      d.sy_state = UCR_SY_IDLE;
      d.rxd_oe   = 1'b0;
      d.rxd_out  = 1'b1;
    end else if (buf_wr) begin
      // A write restarts the shifter even over a reception in progress
      d.sy_state = UCR_SY_TX;
      d.sy_sh    = i_wdata;
      d.sy_bit   = 3'h0;
      d.sy_phase = 1'b0;
      d.txd      = 1'b1;
      d.rxd_oe   = 1'b1;
      d.rxd_out  = 1'b1;
    end else begin
      case (q.sy_state)
        UCR_SY_IDLE: begin
          d.txd     = 1'b1;
          d.rxd_oe  = 1'b0;
          d.rxd_out = 1'b1;
          if (sy_start) begin
            d.sy_state = UCR_SY_RX;
            d.sy_bit   = 3'h0;
            d.sy_phase = 1'b0;
          end
        end
        UCR_SY_TX, UCR_SY_RX: begin
          if (osc_tick) begin
            d.sy_phase = !q.sy_phase;
            if (!q.sy_phase) begin
              // Falling shift clock: next data bit goes out
              d.txd = 1'b0;
              if (q.sy_state == UCR_SY_TX) begin
                d.rxd_out = q.sy_sh[0];
              end
            end else begin
              // Rising shift clock: the partner has had half a period
              d.txd = 1'b1;
              if (q.sy_state == UCR_SY_RX) begin
                d.sy_sh = {i_rxd, q.sy_sh[7:1]};
              end else begin
                d.sy_sh = {1'b1, q.sy_sh[7:1]};
              end
              d.sy_bit = q.sy_bit + 3'h1;
              if (q.sy_bit == 3'h7) begin
                // Last bit and its drive hold one cycle past the final
                // rising clock, so a partner latching on it still sees it
                d.sy_state = UCR_SY_IDLE;
                if (q.sy_state == UCR_SY_TX) begin
                  ti_set = 1'b1;
                end else begin
                  ri_set  = 1'b1;
                  rx_load = 1'b1;
                  rx_byte = {i_rxd, q.sy_sh[7:1]};
                  rb8_val = q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RB8];
                end
              end
            end
          end
        end
        default: d.sy_state = UCR_SY_IDLE;
      endcase
    end

    // Asynchronous transmitter
    if (mode == UCR_MODE0) begin
      d.tx_state = UCR_AS_IDLE;
    end else if (buf_wr) begin
      // Stop bit in slot 10 after the ninth bit in modes 2/3, in slot 9 in mode 1
      d.tx_sh    = {1'b1,
                    (mode == UCR_MODE1) ? 1'b1 : q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_TB8],
                    i_wdata, 1'b0};
      d.tx_state = UCR_AS_RUN;
      d.tx_sub   = 4'h0;
      d.tx_bit   = 4'h0;
      d.txd      = 1'b0;
    end else if ((q.tx_state == UCR_AS_RUN) && tx_tick) begin
      d.tx_sub = q.tx_sub + 4'h1;
      if (q.tx_sub == `UCR_OVS_LAST) begin
        d.tx_bit = q.tx_bit + 4'h1;
        d.tx_sh  = {1'b1, q.tx_sh[10:1]};
        d.txd    = q.tx_sh[1];
        if (q.tx_bit == tx_bits - 4'h2) begin
          ti_set = 1'b1;
        end
        if (q.tx_bit == tx_bits - 4'h1) begin
          d.tx_state = UCR_AS_IDLE;
          d.txd      = 1'b1;
        end
      end
    end else if (q.tx_state == UCR_AS_IDLE) begin
      d.txd = 1'b1;
    end

    // Asynchronous receiver
    if ((mode == UCR_MODE0) || !q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_REN]) begin
      d.rx_state = UCR_AS_IDLE;
      d.rx_last  = 1'b0;
    end else if (rx_tick) begin
      case (q.rx_state)
        UCR_AS_IDLE: begin
          d.rx_last = i_rxd;
          if (q.rx_last && !i_rxd) begin
            d.rx_state = UCR_AS_RUN;
            d.rx_sub   = 4'h0;
            d.rx_bit   = 4'h0;
          end
        end
        UCR_AS_RUN: begin
          d.rx_sub = q.rx_sub + 4'h1;
          // Sample only at the centre; edges and glitches go unseen
          if (q.rx_sub == `UCR_OVS_MID) begin
            // Sub-count runs on, so the next centre lies sixteen ticks on
            d.rx_bit = q.rx_bit + 4'h1;
            if (q.rx_bit == 4'h0) begin
              if (i_rxd) begin
                d.rx_state = UCR_AS_IDLE;
                d.rx_last  = 1'b1;
              end
            end else if (q.rx_bit == `UCR_RX_DECIDE) begin
              // Stop bit in mode 1, ninth bit in modes 2 and 3
              d.rx_state = UCR_AS_IDLE;
              d.rx_last  = i_rxd;
              if (!q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RI] &&
                  (!q.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_MP] || i_rxd)) begin
                ri_set  = 1'b1;
                rx_load = 1'b1;
                rx_byte = q.rx_sh;
                rb8_val = i_rxd;
              end
            end else begin
              d.rx_sh = {i_rxd, q.rx_sh[7:1]};
            end
          end else if (q.rx_sub == `UCR_OVS_LAST) begin
            d.rx_sub = 4'h0;
          end
        end
        default: d.rx_state = UCR_AS_IDLE;
      endcase
    end

    // Hardware sets win over a software clear in the same cycle
    if (rx_load) begin
      d.rxbuf                  = rx_byte;
      d.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RB8]    = rb8_val;
    end
    d.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_TI] = d.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_TI] | ti_set;
    d.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RI] = d.serial_control_register[`UCR_SERIAL_CONTROL_REGISTER_RI] | ri_set;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      q          <= '0;
      q.serial_control_register     <= `UCR_SERIAL_CONTROL_REGISTER_RESET;
      q.power_and_baud_control     <= `UCR_POWER_AND_BAUD_CONTROL_RESET;
      q.rsel     <= `UCR_RSEL_RESET;
      q.sy_state <= UCR_SY_IDLE;
      q.tx_state <= UCR_AS_IDLE;
      q.rx_state <= UCR_AS_IDLE;
      q.sy_sh    <= 8'hff;
      q.tx_sh    <= 11'h7ff;
      q.txd      <= 1'b1;
      q.rxd_out  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_rdata   = q.rdata;
  assign o_txd     = q.txd;
  assign o_rxd_out = q.rxd_out;
  assign o_rxd_oe  = q.rxd_oe;

endmodule : ucr_serial_port
`default_nettype wire

// File: ucr_serial_port_checker.sv
// Timing and register checks on the serial port's own ports
`timescale 1ns/1ns
`default_nettype none
`include "ucr_defines.svh"
module ucr_serial_port_checker (
  // Clock, reset and register port
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  // Pins
  input  wire logic       o_txd,
  input  wire logic       o_rxd_oe
);
  logic [1:0] mode_q;
  logic [2:0] rsel_q;
  logic [3:0] rise_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Shadows rebuilt from bus writes, so no internal probe is needed
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_q <= 2'h0;
      rsel_q <= 3'h0;
      rise_q <= 4'h0;
    end else begin
      if (i_wr && i_addr == `UCR_ADDR_SERIAL_CONTROL_REGISTER) mode_q <= i_wdata[7:6];
      if (i_wr && i_addr == `UCR_ADDR_RSEL) rsel_q <= i_wdata[2:0];
      if (i_wr && i_addr == `UCR_ADDR_SERIAL_DATA_BUFFER) rise_q <= 4'h0;
      else if ($rose(o_txd) && rise_q != 4'hf) rise_q <= rise_q + 4'h1;
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside its answer cycle");
  a_power_and_baud_control_rsvd: assert property (i_rd && i_addr == `UCR_ADDR_POWER_AND_BAUD_CONTROL
    |=> o_rdata[6:5] == 2'h0) else $error("unused control bits read back");
  a_rsel_back: assert property (i_rd && i_addr == `UCR_ADDR_RSEL
    |=> o_rdata[2:0] == rsel_q) else $error("rate select readback wrong");
  a_tx_async: assert property (i_wr && i_addr == `UCR_ADDR_SERIAL_DATA_BUFFER
    && mode_q != 2'h0 |=> !o_txd) else $error("frame did not start");
  a_m0_drive: assert property (i_wr && i_addr == `UCR_ADDR_SERIAL_DATA_BUFFER
    && mode_q == 2'h0 |=> o_rxd_oe) else $error("data pin not driven");
  a_oe_mode0: assert property (o_rxd_oe |-> mode_q == 2'h0)
    else $error("data pin driven outside shift mode");
  a_m0_half: assert property (mode_q == 2'h0 && !rsel_q[2]
    && $fell(o_txd) |-> !o_txd [*6] ##1 o_txd)
    else $error("shift clock low phase not six cycles");
  a_m0_eight: assert property (mode_q == 2'h0 && $fell(o_rxd_oe)
    |-> rise_q + {3'h0, $rose(o_txd)} == 4'h8)
    else $error("shift did not give eight clocks");
endmodule : ucr_serial_port_checker
bind ucr_serial_port ucr_serial_port_checker ucr_serial_port_checker_i (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_txd(o_txd),
  .o_rxd_oe(o_rxd_oe));
`default_nettype wire

// File: ucr_shift_slave.sv
// Shift-mode slave register on the far side of the serial pins
`timescale 1ns/1ns
`default_nettype none
module ucr_shift_slave (
  // Clock and control
  input  wire logic       i_mclk,
  input  wire logic       i_en,
  input  wire logic       i_load,
  input  wire logic [7:0] i_byte,
  // Serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_pin,
  output logic            o_data,
  output logic      [7:0] o_got
);
  logic [7:0] send_q;
  logic       sclk_q;
  // Only follows the shift clock, never makes one
  always_ff @(posedge i_mclk) begin
    sclk_q <= i_sclk;
    if (i_load) begin
      send_q <= i_byte;
    end else if (i_en && i_sclk && !sclk_q) begin
      // Spent bits refill inverted so stale data never looks valid
      send_q <= {~send_q[0], send_q[7:1]};
      o_got  <= {i_pin, o_got[7:1]};
    end
  end
  assign o_data = send_q[0];
endmodule : ucr_shift_slave
`default_nettype wire

// File: ucr_tick_div.sv
// Enable-pulse divider: one tick every i_div enabled cycles
`timescale 1ns/1ns
`default_nettype none
module ucr_tick_div (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_en,
  input  wire logic       i_clr,
  input  wire logic [3:0] i_div,
  // Tick
  output logic            o_tick
);
  import ucr_pkg::*;

  ucr_div_t q;
  ucr_div_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (i_clr) begin
      d.cnt = 4'h0;
    end else if (i_en) begin
      if (q.cnt >= i_div - 4'h1) begin
        d.cnt  = 4'h0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule : ucr_tick_div
`default_nettype wire
